// [hdl/ult_pkg.sv]
//
// Purpose: constants and carrier types for the port link timer block
// Assumes: core clock of 125 MHz, synchronous active-low reset
// Notes:   timeouts are given in ns; cycle counts derive from the clock period
//
// Behaviour
// - wait 10us, not 3us, for header acknowledgement
// - turnaround exceeded blocks link communication start
// - initiator timer runs awaiting low-power response
// - acceptor timer runs during entry handshake
// - exit timer bounds U1/U2 exit sequence
// - all three power timer limits raised
// - connected, suspended, wake enabled, mask uncleared sends wake
// - extended behaviour present from revision C on
//
package ult_pkg;

  // ===========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS     = 8;
  localparam int unsigned HP_LEGACY_NS      = 3000;
  localparam int unsigned HP_EXT_NS         = 10000;
  localparam int unsigned LPM_INIT_LEG_NS   = 6000;
  localparam int unsigned LPM_INIT_EXT_NS   = 12000;
  localparam int unsigned LPM_ACC_LEG_NS    = 6000;
  localparam int unsigned LPM_ACC_EXT_NS    = 12000;
  localparam int unsigned LPM_EXIT_LEG_NS   = 6000;
  localparam int unsigned LPM_EXIT_EXT_NS   = 12000;
  // all waits round down to whole cycles
  localparam int unsigned HP_LEGACY_CYC     = HP_LEGACY_NS / CLK_PERIOD_NS;
  localparam int unsigned HP_EXT_CYC        = HP_EXT_NS / CLK_PERIOD_NS;
  localparam int unsigned LPM_INIT_LEG_CYC  = LPM_INIT_LEG_NS / CLK_PERIOD_NS;
  localparam int unsigned LPM_INIT_EXT_CYC  = LPM_INIT_EXT_NS / CLK_PERIOD_NS;
  localparam int unsigned LPM_ACC_LEG_CYC   = LPM_ACC_LEG_NS / CLK_PERIOD_NS;
  localparam int unsigned LPM_ACC_EXT_CYC   = LPM_ACC_EXT_NS / CLK_PERIOD_NS;
  localparam int unsigned LPM_EXIT_LEG_CYC  = LPM_EXIT_LEG_NS / CLK_PERIOD_NS;
  localparam int unsigned LPM_EXIT_EXT_CYC  = LPM_EXIT_EXT_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W             = 12;

  // ===========================================================
  // revision gate
  localparam logic [3:0]  REV_C             = 4'h2;

  // ===========================================================
  // types
  typedef enum logic [2:0] {
    LS_ACTIVE   = 3'b000,
    LS_REQ_WAIT = 3'b001,
    LS_ACC_HS   = 3'b010,
    LS_LOW      = 3'b011,
    LS_EXIT     = 3'b100
  } ult_lstate_t;

  typedef struct packed {
    logic hp_fail;
    logic init_tmo;
    logic acc_tmo;
    logic exit_tmo;
  } ult_events_t;

endpackage : ult_pkg

// [hdl/ult_port_timers.sv]
//
// Purpose: header packet turnaround, link power timers and auto remote wake
// Assumes: all inputs synchronous to clk_sys_i; one port
// Notes:   limits chosen per silicon revision strap sampled each cycle
//
`timescale 1ns/1ps
`default_nettype none

module ult_port_timers
  import ult_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  // silicon revision
  input  wire logic [3:0]  rev_i,
  // header packet turnaround
  input  wire logic        hp_sent_i,
  input  wire logic        hp_ack_i,
  // low-power entry, initiator side
  input  wire logic        lp_req_send_i,
  input  wire logic        lp_resp_i,
  // low-power entry, acceptor side
  input  wire logic        lp_req_accept_i,
  input  wire logic        lp_hs_done_i,
  // low-power exit
  input  wire logic        lp_exit_start_i,
  input  wire logic        lp_exit_done_i,
  // suspend and wake
  input  wire logic        port_connected_i,
  input  wire logic        port_suspended_i,
  input  wire logic        remote_wake_en_i,
  input  wire logic        conn_change_mask_i,
  // outputs
  output logic             link_comm_en_o,
  output logic             link_low_power_o,
  output logic             wake_up_o,
  output ult_events_t      events_o
);

  // ===========================================================
  // limit selection
  logic                    ext_q;
  logic        [CNT_W-1:0] hp_lim;
  logic        [CNT_W-1:0] init_lim;
  logic        [CNT_W-1:0] acc_lim;
  logic        [CNT_W-1:0] exit_lim;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      ext_q <= 1'b0;
    else
      ext_q <= (rev_i >= REV_C);
  end

  assign hp_lim   = ext_q ? CNT_W'(HP_EXT_CYC) : CNT_W'(HP_LEGACY_CYC);
  assign init_lim = ext_q ? CNT_W'(LPM_INIT_EXT_CYC) : CNT_W'(LPM_INIT_LEG_CYC);
  assign acc_lim  = ext_q ? CNT_W'(LPM_ACC_EXT_CYC) : CNT_W'(LPM_ACC_LEG_CYC);
  assign exit_lim = ext_q ? CNT_W'(LPM_EXIT_EXT_CYC) : CNT_W'(LPM_EXIT_LEG_CYC);

  // ===========================================================
  // header packet turnaround
  logic                    hp_run_q;
  logic        [CNT_W-1:0] hp_cnt_q;
  logic                    hp_expire;

  assign hp_expire = hp_run_q && !hp_ack_i && (hp_cnt_q >= hp_lim - 1'b1);

  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      hp_run_q <= 1'b0;
      hp_cnt_q <= '0;
    end
    else if (hp_run_q)
    begin
      hp_run_q <= !(hp_ack_i || hp_expire);
      hp_cnt_q <= hp_cnt_q + 1'b1;
    end
    else if (hp_sent_i && link_comm_en_o)
    begin
      hp_run_q <= 1'b1;
      hp_cnt_q <= '0;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      link_comm_en_o <= 1'b1;
    else if (hp_expire)
      link_comm_en_o <= 1'b0;
  end

  // ===========================================================
  // link power state machine, one shared counter
  ult_lstate_t             ls_q;
  ult_lstate_t             ls_d;
  logic        [CNT_W-1:0] pm_cnt_q;
  logic        [CNT_W-1:0] pm_lim;
  logic                    pm_expire;
  logic                    pm_timing;
  logic                    init_tmo;
  logic                    acc_tmo;
  logic                    exit_tmo;

  assign pm_lim    = (ls_q == LS_REQ_WAIT) ? init_lim :
                     (ls_q == LS_ACC_HS)   ? acc_lim  : exit_lim;
  assign pm_timing = (ls_q == LS_REQ_WAIT) || (ls_q == LS_ACC_HS) || (ls_q == LS_EXIT);
  assign pm_expire = pm_timing && (pm_cnt_q >= pm_lim - 1'b1);
  assign init_tmo  = (ls_q == LS_REQ_WAIT) && pm_expire && !lp_resp_i;
  assign acc_tmo   = (ls_q == LS_ACC_HS) && pm_expire && !lp_hs_done_i;
  assign exit_tmo  = (ls_q == LS_EXIT) && pm_expire && !lp_exit_done_i;

  always_comb
  begin
    ls_d = ls_q;
    case (ls_q)
      LS_ACTIVE:
        if (lp_req_send_i)
          ls_d = LS_REQ_WAIT;
        else if (lp_req_accept_i)
          ls_d = LS_ACC_HS;
      LS_REQ_WAIT:
        if (lp_resp_i)
          ls_d = LS_LOW;
        else if (init_tmo)
          ls_d = LS_ACTIVE;
      LS_ACC_HS:
        if (lp_hs_done_i)
          ls_d = LS_LOW;
        else if (acc_tmo)
          ls_d = LS_ACTIVE;
      LS_LOW:
        if (lp_exit_start_i)
          ls_d = LS_EXIT;
      // exit timeout also lands in active; recovery is the caller's job
      LS_EXIT:
        if (lp_exit_done_i || exit_tmo)
          ls_d = LS_ACTIVE;
      default:
        ls_d = LS_ACTIVE;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      ls_q     <= LS_ACTIVE;
      pm_cnt_q <= '0;
    end
    else
    begin
      ls_q     <= ls_d;
      pm_cnt_q <= (ls_d != ls_q) ? '0 : (pm_timing ? pm_cnt_q + 1'b1 : '0);
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      link_low_power_o <= 1'b0;
      events_o         <= '0;
    end
    else
    begin
      link_low_power_o <= (ls_d == LS_LOW);
      events_o         <= '{hp_fail: hp_expire, init_tmo: init_tmo,
                            acc_tmo: acc_tmo, exit_tmo: exit_tmo};
    end
  end

  // ===========================================================
  // automatic remote wake
  logic                    wake_cond;
  logic                    wake_cond_q;

  assign wake_cond = ext_q && port_connected_i && port_suspended_i
                     && remote_wake_en_i && conn_change_mask_i;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      wake_cond_q <= 1'b0;
      wake_up_o   <= 1'b0;
    end
    else
    begin
      wake_cond_q <= wake_cond;
      wake_up_o   <= wake_cond && !wake_cond_q;
    end
  end

  // ===========================================================
  // checks
  // budget reached exactly
  property p_hp_budget;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (hp_run_q && ext_q && hp_cnt_q == CNT_W'(HP_EXT_CYC - 1) && !hp_ack_i)
      |=> !link_comm_en_o;
  endproperty
  a_hp_budget: assert property (p_hp_budget) else $error("turnaround overrun missed");

  property p_comm_stays_off;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    !link_comm_en_o |=> !link_comm_en_o;
  endproperty
  a_comm_stays_off: assert property (p_comm_stays_off) else $error("comm reenabled");

  property p_init_len;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    init_tmo |-> pm_cnt_q == init_lim - 1'b1;
  endproperty
  a_init_len: assert property (p_init_len) else $error("initiator timer length");

  property p_acc_ok;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (ls_q == LS_ACC_HS && lp_hs_done_i) |=> link_low_power_o;
  endproperty
  a_acc_ok: assert property (p_acc_ok) else $error("acceptor entry lost");

  // exit bounded
  // own age counter: the exit limit is far beyond a cheap delay range
  logic        [CNT_W-1:0] exit_age_q;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      exit_age_q <= '0;
    else if (ls_q == LS_EXIT)
      exit_age_q <= exit_age_q + 1'b1;
    else
      exit_age_q <= '0;
  end

  sequence s_in_exit;
    ls_q == LS_EXIT;
  endsequence
  property p_exit_bound;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    s_in_exit |-> exit_age_q < exit_lim;
  endproperty
  a_exit_bound: assert property (p_exit_bound) else $error("exit unbounded");

  property p_ext_lim;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    ext_q |-> init_lim > CNT_W'(LPM_INIT_LEG_CYC) && exit_lim > CNT_W'(LPM_EXIT_LEG_CYC);
  endproperty
  a_ext_lim: assert property (p_ext_lim) else $error("limits not raised");

  property p_wake;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (wake_cond && !wake_cond_q) |=> wake_up_o;
  endproperty
  a_wake: assert property (p_wake) else $error("wake not sent");

  property p_legacy;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    !ext_q |=> !wake_up_o;
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy wake");

  property p_abandon;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (init_tmo || acc_tmo) |=> ls_q == LS_ACTIVE && !link_low_power_o;
  endproperty
  a_abandon: assert property (p_abandon) else $error("transition not abandoned");

endmodule : ult_port_timers

`default_nettype wire

// [tb/ult_link_partner.sv]
// Purpose: link partner answering the port's requests
// Assumes: answer comes dly_i cycles after a request; dly_i of zero never answers
// Notes:   one answer bit per request bit; idle answers sit low
`timescale 1ns/1ps
`default_nettype none
module ult_link_partner (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // requests and answer delay
  input  wire logic [3:0]  req_i,
  input  wire logic [11:0] dly_i,
  // answers
  output logic [3:0]       resp_o = 4'h0
);
  logic [11:0] cnt_q [4];
  // ============================================
  // answer timing
  // silent partner never starts traffic
  always @(posedge clk_i)
    for (int i = 0; i < 4; i++)
      cnt_q[i] <= !rstn_i ? 12'h000 : req_i[i] ? dly_i : cnt_q[i] - 12'(cnt_q[i] != 12'h000);
  always @(negedge clk_i)
    for (int i = 0; i < 4; i++)
      resp_o[i] <= cnt_q[i] == 12'h001;
endmodule : ult_link_partner
`default_nettype wire

// [tb/usb3_port_link_timer_compliance_bench.sv]
// Purpose: self-checking bench for the port link timers
// Assumes: partner delay of zero means no answer
// Notes:   req, resp and event bits run hp, init, acc, exit
`timescale 1ns/1ps
`default_nettype none
module usb3_port_link_timer_compliance_bench import ult_pkg::*;;
  logic        clk_sys_i = 1'b0;
  logic        rstn_i    = 1'b0;
  logic [3:0]  rev       = REV_C;
  logic [3:0]  req       = 4'h0;
  logic [3:0]  sus       = 4'h0;
  logic [11:0] dly       = 12'h000;
  logic [3:0]  resp;
  logic [3:0]  evt;
  logic        comm_en;
  logic        low_pwr;
  logic        wake;
  int          miscompares = 0;
  int          comparisons = 0;
  int          wakes = 0;
  int          ecnt [4] = '{default: 0};

  // ============================================
  // design and partner
  ult_port_timers u_dut (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .rev_i(rev),
    .hp_sent_i(req[3]), .hp_ack_i(resp[3]), .lp_req_send_i(req[2]), .lp_resp_i(resp[2]),
    .lp_req_accept_i(req[1]), .lp_hs_done_i(resp[1]),
    .lp_exit_start_i(req[0]), .lp_exit_done_i(resp[0]),
    .port_connected_i(sus[3]), .port_suspended_i(sus[2]), .remote_wake_en_i(sus[1]),
    .conn_change_mask_i(sus[0]), .link_comm_en_o(comm_en), .link_low_power_o(low_pwr),
    .wake_up_o(wake), .events_o(evt));
  ult_link_partner u_far (.clk_i(clk_sys_i), .rstn_i(rstn_i), .req_i(req), .dly_i(dly),
    .resp_o(resp));

  initial forever #4 clk_sys_i = ~clk_sys_i;
  // pulses counted once settled, clear of the bench's falling-edge drive
  always @(posedge clk_sys_i)
  begin
    #2;
    wakes = wakes + int'(wake);
    for (int i = 0; i < 4; i++)
      ecnt[i] = ecnt[i] + int'(evt[i]);
  end

  // ============================================
  // helpers
  task check(input string what, input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : check

  task tally_and_finish;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  task cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : cyc

  task do_reset(input logic [3:0] r);
    cyc(1);
    rev = r;
    sus = 4'h0;
    rstn_i = 1'b0;
    cyc(10);
    rstn_i = 1'b1;
    cyc(1);
  endtask : do_reset

  task fire(input int i);
    req[i] = 1'b1;
    cyc(1);
    req[i] = 1'b0;
  endtask : fire

  task wait_low;
    for (int k = 0; k < 8 && low_pwr !== 1'b1; k++)
      cyc(1);
  endtask : wait_low

  // ============================================
  // scenarios
  task t_hp_ok;
    int e0;
    e0 = ecnt[3];
    dly = 12'd1240;
    fire(3);
    cyc(1300);
    check("hp_fail", 12'(ecnt[3] - e0), 12'h000);
    check("comm_en", 12'(comm_en), 12'h001);
    $display("t_hp_ok done");
  endtask : t_hp_ok

  task t_hp_over(input logic [3:0] r, input int n);
    do_reset(r);
    dly = 12'h000;
    fire(3);
    cyc(n - 1);
    check("comm_en", 12'(comm_en), 12'h001);
    cyc(1);
    check("comm_en", 12'(comm_en), 12'h000);
    check("hp_fail", 12'(evt[3]), 12'h001);
    dly = 12'h002;
    fire(3);
    check("hp_fail", 12'(evt[3]), 12'h000);
    cyc(5);
    check("comm_en", 12'(comm_en), 12'h000);
    $display("t_hp_over done");
  endtask : t_hp_over

  task t_lp_walk;
    dly = 12'h003;
    for (int ch = 2; ch > 0; ch--)
    begin
      fire(ch);
      wait_low;
      check("low_pwr", 12'(low_pwr), 12'h001);
      fire(0);
      check("low_pwr", 12'(low_pwr), 12'h000);
      cyc(5);
    end
    check("tmo", 12'(ecnt[2] + ecnt[1] + ecnt[0]), 12'h000);
    $display("t_lp_walk done");
  endtask : t_lp_walk

  task t_lp_tmo(input int ch, input int lim);
    int k;
    dly = 12'h003;
    if (ch == 0)
    begin
      fire(2);
      cyc(6);
    end
    dly = 12'h000;
    fire(ch);
    for (k = 1; k < lim + 8 && evt[ch] !== 1'b1; k++)
      cyc(1);
    check("tmo_cycle", 12'(k >= lim && k <= lim + 2), 12'h001);
    check("low_pwr", 12'(low_pwr), 12'h000);
    dly = 12'h003;
    fire(1);
    wait_low;
    check("low_pwr", 12'(low_pwr), 12'h001);
    fire(0);
    cyc(6);
    $display("t_lp_tmo done");
  endtask : t_lp_tmo

  task t_wake;
    int w0;
    do_reset(REV_C);
    w0 = wakes;
    sus = 4'hF;
    cyc(8);
    check("wake", 12'(wakes - w0), 12'h001);
    sus[0] = 1'b0;
    cyc(3);
    sus[0] = 1'b1;
    cyc(3);
    sus[1] = 1'b0;
    cyc(3);
    check("wake", 12'(wakes - w0), 12'h002);
    do_reset(4'h1);
    w0 = wakes;
    sus = 4'hF;
    cyc(5);
    check("wake", 12'(wakes - w0), 12'h000);
    $display("t_wake done");
  endtask : t_wake

  initial
  begin
    repeat (30000) @(posedge clk_sys_i);
    miscompares++;
    tally_and_finish;
  end

  initial
  begin
    do_reset(REV_C);
    check("comm_en", 12'(comm_en), 12'h001);
    check("out", 12'({low_pwr, wake, evt}), 12'h000);
    t_hp_ok;
    t_hp_over(REV_C, HP_EXT_CYC);
    t_hp_over(4'h1, HP_LEGACY_CYC);
    do_reset(REV_C);
    t_lp_walk;
    t_lp_tmo(2, LPM_INIT_EXT_CYC);
    t_lp_tmo(1, LPM_ACC_EXT_CYC);
    t_lp_tmo(0, LPM_EXIT_EXT_CYC);
    do_reset(4'h1);
    t_lp_tmo(2, LPM_INIT_LEG_CYC);
    t_wake;
    tally_and_finish;
  end
endmodule : usb3_port_link_timer_compliance_bench
`default_nettype wire
